// ### hdl/crs_defs.svh
// Constants of the CPU register set: offsets, fields, reset values, counts.
// Assumes inclusion by the package and the core, on one 250 MHz clock.
//
// Functional notes
// - Stop exit with internal oscillator waits 4064 cycles before running.
// - With the delay option bit clear, stop restart waits four cycles.
// - Two 8-bit accumulators, also usable together as one 16-bit value.
// - Indexed address is index register plus unsigned 8-bit offset.
// - Secondary index ops need a prefix byte and one extra cycle.
// - Stack pointer names next free byte; push decrements, pull increments.
// - Instruction pointer always holds the next instruction address.
// - Carry follows arithmetic carry or borrow and shift or rotate out.
// - Overflow set on arithmetic overflow, cleared otherwise.
// - Zero flag set when result is zero, cleared otherwise.
// - Negative flag takes the result's most significant bit.
// - Interrupt mask flag blocks every maskable interrupt request.
// - Half carry set on carry from bit 3 to 4 in adds.
// - Nonmaskable mask set only by hardware, cleared by instruction or by a register port write.
// - Stop acts as no-operation while the stop-disable flag is set.
// - Direct address takes low byte from operand, high byte zero.
// - Immediate operand bytes follow opcode, as many as register width.
// - Prefix bytes before an opcode select pages two to four.
// - With CRS_CTL_EXP set, during wait the address port shows stack pointer minus eight.
// - Steady-state outputs hold their level during wait and stop.
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

`define CRS_ADR_ACC1   4'h0
`define CRS_ADR_ACC2   4'h1
`define CRS_ADR_PIDX   4'h2
`define CRS_ADR_SIDX   4'h3
`define CRS_ADR_STK    4'h4
`define CRS_ADR_IPTR   4'h5
`define CRS_ADR_FLAGS  4'h6
`define CRS_ADR_CTL    4'h7
`define CRS_ADR_STAT   4'h8
`define CRS_ADR_POUT   4'h9

`define CRS_CTL_DLY    0
`define CRS_CTL_EXP    1

`define CRS_F_S        7
`define CRS_F_X        6
`define CRS_F_H        5
`define CRS_F_I        4
`define CRS_F_N        3
`define CRS_F_Z        2
`define CRS_F_V        1
`define CRS_F_C        0

`define CRS_RST_FLAGS  8'hD0
`define CRS_RST_CTL    2'h1
`define CRS_RST_W16    16'h0000
`define CRS_RST_W8     8'h00

`define CRS_DLY_LONG   12'hFE0
`define CRS_DLY_SHORT  12'h004
`define CRS_WAIT_BACK  16'h0008

`define CRS_PRE_P2     8'h18
`define CRS_PRE_P3     8'h1A
`define CRS_PRE_P4     8'hCD
`define CRS_PAGE1      2'h0
`define CRS_PAGE2      2'h1
`define CRS_PAGE3      2'h2
`define CRS_PAGE4      2'h3

`endif

// ### hdl/crs_pkg.sv
// Types of the CPU register set: run modes, operations, address modes.
// Assumes the constants header sits beside it.
`include "crs_defs.svh"
package crs_pkg;

   typedef enum logic [1:0] {
      CRS_RUN     = 2'b00,
      CRS_WAIT    = 2'b01,
      CRS_STOP    = 2'b10,
      CRS_RESTART = 2'b11
   } crs_mode_t;

   typedef enum logic [3:0] {
      CRS_OP_NOP  = 4'h0,
      CRS_OP_ADD  = 4'h1,
      CRS_OP_ADC  = 4'h2,
      CRS_OP_SUB  = 4'h3,
      CRS_OP_AND  = 4'h4,
      CRS_OP_LD   = 4'h5,
      CRS_OP_ASL  = 4'h6,
      CRS_OP_ROL  = 4'h7,
      CRS_OP_ABA  = 4'h8,
      CRS_OP_ADDD = 4'h9,
      CRS_OP_LDD  = 4'hA,
      CRS_OP_SEI  = 4'hB,
      CRS_OP_CLI  = 4'hC,
      CRS_OP_TAP  = 4'hD,
      CRS_OP_RTI  = 4'hE
   } crs_op_t;

   typedef enum logic [2:0] {
      CRS_AM_INH   = 3'h0,
      CRS_AM_IMM8  = 3'h1,
      CRS_AM_IMM16 = 3'h2,
      CRS_AM_DIR   = 3'h3,
      CRS_AM_IDX   = 3'h4
   } crs_am_t;

endpackage : crs_pkg

// ### hdl/crs_core.sv
// CPU register set: accumulators, index, stack, pointer, flags, low power.
// Assumes a same-clock sequencer on the op port; irq pins are asynchronous.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "crs_defs.svh"

module crs_core
   import crs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [15:0] reg_rdata,
   input  wire logic        op_valid,
   input  wire crs_op_t     op_code,
   input  wire logic        op_acc_sel,
   input  wire crs_am_t     op_am,
   input  wire logic        op_sidx_sel,
   input  wire logic [15:0] op_mem,
   input  wire logic        fetch_valid,
   input  wire logic [7:0]  fetch_byte,
   input  wire logic        stack_push,
   input  wire logic        stack_pull,
   input  wire logic        stop_instr,
   input  wire logic        wait_for_interrupt_instr,
   input  wire logic        nonmaskable_interrupt_pin_ack,
   input  wire logic        irq_pin,
   input  wire logic        nonmaskable_interrupt_pin,
   output var  logic        irq_req,
   output var  logic [15:0] addr_port,
   output var  logic [15:0] eff_addr,
   output var  logic [2:0]  instr_len,
   output var  logic        extra_cycle,
   output var  logic [1:0]  opcode_page,
   output var  logic [7:0]  port_out,
   output var  logic [7:0]  flags_out,
   output var  crs_mode_t   run_mode
);
   typedef struct packed {
      logic [7:0]  acc1;
      logic [7:0]  acc2;
      logic [15:0] primary_index;
      logic [15:0] secondary_index;
      logic [15:0] stack_top_pointer;
      logic [15:0] instruction_pointer;
      logic [7:0]  flags_register;
      logic [1:0]  ctl;
      logic [7:0]  pout;
      crs_mode_t   mode;
      logic [11:0] dly_cnt;
      logic        irq_s1;
      logic        irq_s2;
      logic        nmi_s1;
      logic        nmi_s2;
      logic        irq_req;
      logic [15:0] addr_port;
      logic [15:0] ea;
      logic [2:0]  len;
      logic        extra;
      logic        pend_pre;
      logic [1:0]  pend_page;
      logic [1:0]  page;
      logic [15:0] rdata;
   } crs_state_t;
   crs_state_t state_q;
   crs_state_t state_d;
   logic       exit_now;
   assign exit_now = state_q.irq_s2 & ~state_q.flags_register[`CRS_F_I];
   // Instruction length in bytes from prefix and address mode
   function automatic logic [2:0] crs_len(input crs_am_t am,
                                         input logic    pre);
      logic [2:0] n;
      n = 3'h1;
      unique case (am)
         CRS_AM_INH:   n = 3'h1;
         CRS_AM_IMM8:  n = 3'h2;
         CRS_AM_IMM16: n = 3'h3;
         CRS_AM_DIR:   n = 3'h2;
         CRS_AM_IDX:   n = 3'h2;
      endcase
      crs_len = n + {2'h0, pre};
   endfunction : crs_len
   always_comb begin
      logic [7:0]  src;
      logic [7:0]  opd;
      logic [7:0]  res;
      logic [8:0]  r9;
      logic [4:0]  h5;
      logic [16:0] r17;
      logic [15:0] idx;
      logic        cin;
      logic        pre;
      logic [7:0]  f;
      src = op_acc_sel ? state_q.acc2 : state_q.acc1;
      opd = op_mem[7:0];
      res = 8'h00;
      r9 = 9'h000;
      h5 = 5'h00;
      r17 = 17'h00000;
      idx = op_sidx_sel ? state_q.secondary_index : state_q.primary_index;
      cin = 1'b0;
      pre = state_q.pend_pre;
      f = state_q.flags_register;
      state_d = state_q;
      state_d.rdata = 16'h0000;
      state_d.irq_s1 = irq_pin;
      state_d.irq_s2 = state_q.irq_s1;
      state_d.nmi_s1 = nonmaskable_interrupt_pin;
      state_d.nmi_s2 = state_q.nmi_s1;
      state_d.irq_req = exit_now;
      // Register port writes
      if (reg_wr) begin
         case (reg_addr)
            `CRS_ADR_ACC1:  state_d.acc1 = reg_wdata[7:0];
            `CRS_ADR_ACC2:  state_d.acc2 = reg_wdata[7:0];
            `CRS_ADR_PIDX:  state_d.primary_index = reg_wdata;
            `CRS_ADR_SIDX:  state_d.secondary_index = reg_wdata;
            `CRS_ADR_STK:   state_d.stack_top_pointer = reg_wdata;
            `CRS_ADR_IPTR:  state_d.instruction_pointer = reg_wdata;
            `CRS_ADR_FLAGS: f = {reg_wdata[7],
                                 reg_wdata[6] & f[`CRS_F_X],
                                 reg_wdata[5:0]};
            `CRS_ADR_CTL:   state_d.ctl = reg_wdata[1:0];
            `CRS_ADR_POUT: if (state_q.mode == CRS_RUN) begin
               state_d.pout = reg_wdata[7:0];
            end
            default: ;
         endcase
      end
      // Register port reads, answered next cycle
      if (reg_rd) begin
         case (reg_addr)
            `CRS_ADR_ACC1:  state_d.rdata = {8'h00, state_q.acc1};
            `CRS_ADR_ACC2:  state_d.rdata = {8'h00, state_q.acc2};
            `CRS_ADR_PIDX:  state_d.rdata = state_q.primary_index;
            `CRS_ADR_SIDX:  state_d.rdata = state_q.secondary_index;
            `CRS_ADR_STK:   state_d.rdata = state_q.stack_top_pointer;
            `CRS_ADR_IPTR:  state_d.rdata = state_q.instruction_pointer;
            `CRS_ADR_FLAGS: state_d.rdata = {8'h00, state_q.flags_register};
            `CRS_ADR_CTL:   state_d.rdata = {14'h0000, state_q.ctl};
            `CRS_ADR_STAT:  state_d.rdata = {12'h000, state_q.page,
                                             state_q.mode};
            `CRS_ADR_POUT:  state_d.rdata = {8'h00, state_q.pout};
            default:        state_d.rdata = 16'h0000;
         endcase
      end
      if (fetch_valid && state_q.mode == CRS_RUN) begin
         if (fetch_byte == `CRS_PRE_P2) begin
            state_d.pend_pre = 1'b1;
            state_d.pend_page = `CRS_PAGE2;
         end else if (fetch_byte == `CRS_PRE_P3) begin
            state_d.pend_pre = 1'b1;
            state_d.pend_page = `CRS_PAGE3;
         end else if (fetch_byte == `CRS_PRE_P4) begin
            state_d.pend_pre = 1'b1;
            state_d.pend_page = `CRS_PAGE4;
         end else begin
            state_d.pend_pre = 1'b0;
            state_d.page = state_q.pend_pre ? state_q.pend_page : `CRS_PAGE1;
         end
      end
      if (stack_push && !stack_pull) begin
         state_d.stack_top_pointer = state_q.stack_top_pointer - 16'h0001;
      end else if (stack_pull && !stack_push) begin
         state_d.stack_top_pointer = state_q.stack_top_pointer + 16'h0001;
      end
      if (op_valid && state_q.mode == CRS_RUN) begin
         pre = state_q.pend_pre | op_sidx_sel;
         state_d.extra = op_sidx_sel;
         state_d.len = crs_len(op_am, pre);
         state_d.pend_pre = 1'b0;
         state_d.instruction_pointer = state_q.instruction_pointer
                                     + {13'h0000, crs_len(op_am, pre)};
         unique case (op_am)
            CRS_AM_INH:   state_d.ea = state_q.instruction_pointer;
            CRS_AM_IMM8,
            CRS_AM_IMM16: state_d.ea = state_q.instruction_pointer
                                     + {15'h0000, pre} + 16'h0001;
            CRS_AM_DIR:   state_d.ea = {8'h00, op_mem[7:0]};
            CRS_AM_IDX:   state_d.ea = idx + {8'h00, op_mem[7:0]};
         endcase
         if (op_code == CRS_OP_ABA) begin
            src = state_q.acc1;
            opd = state_q.acc2;
         end
         cin = (op_code == CRS_OP_ADC) & f[`CRS_F_C];
         h5 = {1'b0, src[3:0]} + {1'b0, opd[3:0]} + {4'h0, cin};
         r9 = {1'b0, src} + {1'b0, opd} + {8'h00, cin};
         r17 = {1'b0, state_q.acc1, state_q.acc2} + {1'b0, op_mem};
         case (op_code)
            CRS_OP_ADD, CRS_OP_ADC, CRS_OP_ABA: begin
               res = r9[7:0];
               f[`CRS_F_H] = h5[4];
               f[`CRS_F_C] = r9[8];
               f[`CRS_F_V] = (src[7] == opd[7]) && (res[7] != src[7]);
            end
            CRS_OP_SUB: begin
               r9 = {1'b0, src} - {1'b0, opd};
               res = r9[7:0];
               f[`CRS_F_C] = r9[8];
               f[`CRS_F_V] = (src[7] != opd[7]) && (res[7] != src[7]);
            end
            CRS_OP_AND: begin
               res = src & opd;
               f[`CRS_F_V] = 1'b0;
            end
            CRS_OP_LD: begin
               res = opd;
               f[`CRS_F_V] = 1'b0;
            end
            CRS_OP_ASL, CRS_OP_ROL: begin
               res = {src[6:0], (op_code == CRS_OP_ROL) & f[`CRS_F_C]};
               f[`CRS_F_C] = src[7];
               f[`CRS_F_V] = res[7] ^ src[7];
            end
            default: ;
         endcase
         case (op_code)
            CRS_OP_ADD, CRS_OP_ADC, CRS_OP_ABA, CRS_OP_SUB,
            CRS_OP_AND, CRS_OP_LD, CRS_OP_ASL, CRS_OP_ROL: begin
               f[`CRS_F_N] = res[7];
               f[`CRS_F_Z] = (res == 8'h00);
               if (op_code == CRS_OP_ABA || !op_acc_sel) begin
                  state_d.acc1 = res;
               end else begin
                  state_d.acc2 = res;
               end
            end
            CRS_OP_ADDD, CRS_OP_LDD: begin
               if (op_code == CRS_OP_LDD) begin
                  r17 = {1'b0, op_mem};
                  f[`CRS_F_V] = 1'b0;
               end else begin
                  f[`CRS_F_C] = r17[16];
                  f[`CRS_F_V] = (state_q.acc1[7] == op_mem[15])
                              && (r17[15] != state_q.acc1[7]);
               end
               f[`CRS_F_N] = r17[15];
               f[`CRS_F_Z] = (r17[15:0] == 16'h0000);
               state_d.acc1 = r17[15:8];
               state_d.acc2 = r17[7:0];
            end
            CRS_OP_SEI: f[`CRS_F_I] = 1'b1;
            CRS_OP_CLI: f[`CRS_F_I] = 1'b0;
            CRS_OP_TAP, CRS_OP_RTI: begin
               f = {op_mem[7], op_mem[6] & f[`CRS_F_X], op_mem[5:0]};
            end
            default: ;
         endcase
      end
      unique case (state_q.mode)
         CRS_RUN: begin
            if (stop_instr) begin
               if (!state_q.flags_register[`CRS_F_S]) begin
                  state_d.mode = CRS_STOP;
               end
            end else if (wait_for_interrupt_instr) begin
               state_d.mode = CRS_WAIT;
               if (state_q.ctl[`CRS_CTL_EXP]) begin
                  state_d.addr_port = state_q.stack_top_pointer
                                    - `CRS_WAIT_BACK;
               end
            end else if (state_q.ctl[`CRS_CTL_EXP]) begin
               state_d.addr_port = state_q.instruction_pointer;
            end
         end
         CRS_WAIT: begin
            if (exit_now
                || (state_q.nmi_s2 && !state_q.flags_register[`CRS_F_X])) begin
               state_d.mode = CRS_RUN;
            end
         end
         CRS_STOP: begin
            if (exit_now || state_q.nmi_s2) begin
               state_d.mode = CRS_RESTART;
               state_d.dly_cnt = state_q.ctl[`CRS_CTL_DLY] ? `CRS_DLY_LONG
                                                           : `CRS_DLY_SHORT;
            end
         end
         CRS_RESTART: begin
            state_d.dly_cnt = state_q.dly_cnt - 12'h001;
            if (state_q.dly_cnt == 12'h001) begin
               state_d.mode = CRS_RUN;
            end
         end
      endcase
      if (nonmaskable_interrupt_pin_ack) begin
         f[`CRS_F_X] = 1'b1;
         f[`CRS_F_I] = 1'b1;
      end
      state_d.flags_register = f;
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= '0;
         state_q.flags_register <= `CRS_RST_FLAGS;
         state_q.ctl <= `CRS_RST_CTL;
         state_q.mode <= CRS_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   assign reg_rdata = state_q.rdata;
   assign irq_req = state_q.irq_req;
   assign addr_port = state_q.addr_port;
   assign eff_addr = state_q.ea;
   assign instr_len = state_q.len;
   assign extra_cycle = state_q.extra;
   assign opcode_page = state_q.page;
   assign port_out = state_q.pout;
   assign flags_out = state_q.flags_register;
   assign run_mode = state_q.mode;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_stop_wake;
      state_q.mode == CRS_STOP && (state_q.nmi_s2 || exit_now)
      && !state_q.ctl[`CRS_CTL_DLY];
   endsequence
   sequence s_short_restart;
      (state_q.mode == CRS_RESTART) [*4] ##1 (state_q.mode == CRS_RUN);
   endsequence

   a_short_restart: assert property (
      s_stop_wake |=> s_short_restart)
      else $error("short restart not four cycles");
   a_long_restart: assert property (
      state_q.mode == CRS_STOP && state_q.nmi_s2 && state_q.ctl[`CRS_CTL_DLY]
      |=> state_q.mode == CRS_RESTART && state_q.dly_cnt == `CRS_DLY_LONG)
      else $error("long restart count wrong");
   a_stop_nop: assert property (
      state_q.mode == CRS_RUN && stop_instr
      && state_q.flags_register[`CRS_F_S] |=> state_q.mode == CRS_RUN)
      else $error("disabled stop took effect");
   a_index_ea: assert property (
      op_valid && state_q.mode == CRS_RUN && op_am == CRS_AM_IDX
      && !op_sidx_sel
      |=> eff_addr == $past(state_q.primary_index) + {8'h00, $past(op_mem[7:0])})
      else $error("indexed address wrong");
   a_direct_ea: assert property (
      op_valid && state_q.mode == CRS_RUN && op_am == CRS_AM_DIR
      |=> eff_addr[15:8] == 8'h00 && eff_addr[7:0] == $past(op_mem[7:0]))
      else $error("direct address wrong");
   a_push_sp: assert property (
      stack_push && !stack_pull && !reg_wr
      |=> state_q.stack_top_pointer
          == $past(state_q.stack_top_pointer) - 16'h0001)
      else $error("push did not decrement");
   a_x_set_hw: assert property (
      $rose(state_q.flags_register[`CRS_F_X])
      |-> $past(nonmaskable_interrupt_pin_ack) || $past(reset))
      else $error("X set without hardware");
   a_wait_addr: assert property (
      state_q.mode == CRS_RUN && wait_for_interrupt_instr && !stop_instr
      && state_q.ctl[`CRS_CTL_EXP]
      |=> addr_port == $past(state_q.stack_top_pointer) - `CRS_WAIT_BACK)
      else $error("wait address wrong");
   a_stop_steady: assert property (
      state_q.mode == CRS_STOP && $past(state_q.mode) == CRS_STOP
      |-> $stable(port_out) && $stable(addr_port))
      else $error("outputs moved during stop");
   a_irq_masked: assert property (
      state_q.flags_register[`CRS_F_I] |=> !irq_req)
      else $error("masked interrupt passed");
endmodule : crs_core
`default_nettype wire

// ### tb/crs_core_bench.sv
// Self-checking bench of the CPU register set core: bus, ops, low power.
// Assumes the design package and constants header on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "crs_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %0t got %h exp %h", $time, g, e); end end

module crs_core_bench
   import crs_pkg::*;
;
   logic        clk, reset, reg_wr, reg_rd, op_valid, op_acc_sel;
   logic        op_sidx_sel, fetch_valid, irq_pin, nmi_pin, irq_req;
   logic        extra_cycle, sel2;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, op_mem, addr_port, eff_addr, v;
   logic [7:0]  fetch_byte, port_out, flags_out;
   logic [4:0]  strb;
   logic [2:0]  instr_len;
   logic [1:0]  opcode_page;
   crs_op_t     op_code;
   crs_am_t     op_am;
   crs_mode_t   run_mode;
   int          bad_count, n_tests;
   logic [7:0]  pre_b [3] = '{8'h18, 8'h1A, 8'hCD};

   crs_core crs_core_i (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .op_valid(op_valid), .op_code(op_code), .op_acc_sel(op_acc_sel),
      .op_am(op_am), .op_sidx_sel(op_sidx_sel), .op_mem(op_mem),
      .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
      .stack_push(strb[0]), .stack_pull(strb[1]), .stop_instr(strb[2]),
      .wait_for_interrupt_instr(strb[3]), .nonmaskable_interrupt_pin_ack(strb[4]),
      .irq_pin(irq_pin), .nonmaskable_interrupt_pin(nmi_pin),
      .irq_req(irq_req), .addr_port(addr_port), .eff_addr(eff_addr),
      .instr_len(instr_len), .extra_cycle(extra_cycle),
      .opcode_page(opcode_page), .port_out(port_out),
      .flags_out(flags_out), .run_mode(run_mode));

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   task finish_test;
      if (bad_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      @(posedge clk);
      reg_wr    <= 1'h0;
   endtask : wr

   task rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge clk);
      reg_rd   <= 1'h0;
      #1 `CHK(reg_rdata, e)
   endtask : rd

   task op(input crs_op_t c, input crs_am_t am, input logic s,
           input logic [15:0] m);
      @(posedge clk);
      op_code     <= c;
      op_am       <= am;
      op_sidx_sel <= s;
      op_mem      <= m;
      op_acc_sel  <= sel2;
      op_valid    <= 1'h1;
      @(posedge clk);
      op_valid    <= 1'h0;
      #1;
   endtask : op

   task strobe(input int k);
      @(posedge clk);
      strb[k] <= 1'h1;
      @(posedge clk);
      strb    <= 5'h00;
      #1;
   endtask : strobe

   task fetch(input logic [7:0] b);
      @(posedge clk);
      fetch_valid <= 1'h1;
      fetch_byte  <= b;
      @(posedge clk);
      fetch_valid <= 1'h0;
      #1;
   endtask : fetch

   task wait_mode(input crs_mode_t m);
      int i;
      i = 0;
      while (run_mode !== m && i < 20) begin
         @(posedge clk);
         #1 i++;
      end
      `CHK(run_mode, m)
      if (run_mode !== m) finish_test();
   endtask : wait_mode

   task restart_len(input int e);
      int i, cnt;
      cnt = 0;
      for (i = 0; i < 5000; i++) begin
         @(posedge clk);
         #1;
         if (run_mode === CRS_RESTART) cnt++;
         else if (cnt != 0) break;
      end
      nmi_pin <= 1'h0;
      `CHK(cnt, e)
      if (i == 5000) finish_test();
   endtask : restart_len

   initial begin
      {reset, reg_wr, reg_rd, op_valid, op_acc_sel, op_sidx_sel} = 6'h20;
      {sel2, fetch_valid, irq_pin, nmi_pin, strb} = 9'h000;
      {reg_addr, reg_wdata, op_mem, fetch_byte} = 44'h0;
      op_code = CRS_OP_NOP;
      op_am = CRS_AM_INH;
      repeat (4) @(posedge clk);
      reset <= 1'h0;
      rd(4'h6, 16'h00D0);
      rd(4'h7, 16'h0001);
      rd(4'hF, 16'h0000);
      wr(4'h0, 16'h0008);
      op(CRS_OP_ADD, CRS_AM_IMM8, 1'h0, 16'h0008);
      `CHK(flags_out, 8'hF0)
      `CHK(eff_addr, 16'h0001)
      rd(4'h5, 16'h0002);
      op(CRS_OP_ADD, CRS_AM_IMM8, 1'h0, 16'h0080);
      `CHK(flags_out, 8'hD8)
      op(CRS_OP_ADD, CRS_AM_IMM8, 1'h0, 16'h0070);
      `CHK(flags_out, 8'hD5)
      wr(4'h0, 16'h0040);
      op(CRS_OP_ADD, CRS_AM_IMM8, 1'h0, 16'h0040);
      `CHK(flags_out, 8'hDA)
      op(CRS_OP_SUB, CRS_AM_IMM8, 1'h0, 16'h0081);
      `CHK(flags_out, 8'hD9)
      op(CRS_OP_ADC, CRS_AM_IMM8, 1'h0, 16'h0000);
      `CHK(flags_out, 8'hF5)
      wr(4'h1, 16'h0081);
      sel2 = 1'h1;
      op(CRS_OP_ASL, CRS_AM_INH, 1'h0, 16'h0000);
      `CHK(flags_out, 8'hF3)
      op(CRS_OP_ROL, CRS_AM_INH, 1'h0, 16'h0000);
      `CHK(flags_out, 8'hF0)
      sel2 = 1'h0;
      rd(4'h1, 16'h0005);
      op(CRS_OP_AND, CRS_AM_IMM8, 1'h0, 16'h0000);
      `CHK(flags_out, 8'hF4)
      wr(4'h0, 16'h0001);
      wr(4'h1, 16'h000F);
      op(CRS_OP_ABA, CRS_AM_INH, 1'h0, 16'h0000);
      `CHK(flags_out, 8'hF0)
      wr(4'h0, 16'h0012);
      wr(4'h1, 16'h00F0);
      op(CRS_OP_ADDD, CRS_AM_IMM16, 1'h0, 16'h0011);
      rd(4'h0, 16'h0013);
      rd(4'h1, 16'h0001);
      wr(4'h2, 16'h1000);
      wr(4'h3, 16'h2000);
      op(CRS_OP_LD, CRS_AM_IDX, 1'h0, 16'h00FF);
      `CHK({eff_addr, instr_len, extra_cycle}, {16'h10FF, 3'h2, 1'h0})
      op(CRS_OP_LD, CRS_AM_IDX, 1'h1, 16'h00FF);
      `CHK({eff_addr, instr_len, extra_cycle}, {16'h20FF, 3'h3, 1'h1})
      op(CRS_OP_LD, CRS_AM_DIR, 1'h0, 16'hFFAB);
      `CHK(eff_addr, 16'h00AB)
      wr(4'h5, 16'h0100);
      op(CRS_OP_LDD, CRS_AM_IMM16, 1'h0, 16'h1234);
      `CHK({eff_addr, instr_len}, {16'h0101, 3'h3})
      rd(4'h5, 16'h0103);
      wr(4'h4, 16'h0100);
      strobe(0);
      strobe(0);
      rd(4'h4, 16'h00FE);
      strobe(1);
      rd(4'h4, 16'h00FF);
      for (int k = 0; k < 3; k++) begin
         fetch(pre_b[k]);
         fetch(8'h20);
         `CHK(opcode_page, 2'(k + 1))
      end
      fetch(8'h20);
      `CHK(opcode_page, 2'h0)
      irq_pin <= 1'h1;
      repeat (4) @(posedge clk);
      #1 `CHK(irq_req, 1'h0)
      op(CRS_OP_CLI, CRS_AM_INH, 1'h0, 16'h0000);
      repeat (3) @(posedge clk);
      #1 `CHK(irq_req, 1'h1)
      op(CRS_OP_SEI, CRS_AM_INH, 1'h0, 16'h0000);
      irq_pin <= 1'h0;
      repeat (3) @(posedge clk);
      #1 `CHK(irq_req, 1'h0)
      strobe(2);
      @(posedge clk);
      #1 `CHK(run_mode, CRS_RUN)
      wr(4'h6, 16'h0050);
      wr(4'h7, 16'h0000);
      strobe(2);
      wait_mode(CRS_STOP);
      nmi_pin <= 1'h1;
      restart_len(4);
      wr(4'h7, 16'h0001);
      strobe(2);
      wait_mode(CRS_STOP);
      nmi_pin <= 1'h1;
      restart_len(4064);
      wr(4'h7, 16'h0003);
      wr(4'h9, 16'h005A);
      wr(4'h4, 16'h0200);
      wr(4'h6, 16'h0000);
      strobe(3);
      wait_mode(CRS_WAIT);
      wr(4'h9, 16'h00A5);
      @(posedge clk);
      #1 `CHK(port_out, 8'h5A)
      `CHK(addr_port, 16'h01F8)
      irq_pin <= 1'h1;
      wait_mode(CRS_RUN);
      irq_pin <= 1'h0;
      wr(4'h6, 16'h0040);
      @(posedge clk);
      #1 `CHK(flags_out[6], 1'h0)
      strobe(4);
      `CHK(flags_out[6], 1'h1)
      op(CRS_OP_TAP, CRS_AM_INH, 1'h0, 16'h0000);
      `CHK(flags_out[6], 1'h0)
      strobe(4);
      `CHK(flags_out[6], 1'h1)
      op(CRS_OP_RTI, CRS_AM_INH, 1'h0, 16'h0000);
      `CHK(flags_out[6], 1'h0)
      finish_test();
   end
endmodule : crs_core_bench
`default_nettype wire
